// *** eeprom_fe_master.sv ***
// Two-wire bus master model: drives SCL and an open-drain SDA.
// Assumes the bench resolves SDA with a pull-up and feeds it back.
`timescale 1ns/100ps
`default_nettype none
module eeprom_fe_master
#(
  parameter int Q = 150  // Bus phase in clocks
)(
  input  wire logic i_sys_clk,  // clock
  input  wire logic i_sda,      // resolved SDA
  output var  logic o_scl,      // SCL drive
  output var  logic o_sda       // 0 pulls SDA
);
  logic spike = 1'b0;
  initial {o_scl, o_sda} = 2'b11;

  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask : cyc

  task automatic start();
    cyc(40);
    o_sda <= 1'b1;
    cyc(Q);
    o_scl <= 1'b1;
    cyc(Q);
    o_sda <= 1'b0;
    cyc(2 * Q);
    o_scl <= 1'b0;
  endtask : start

  task automatic stop();
    cyc(40);
    o_sda <= 1'b0;
    cyc(Q);
    o_scl <= 1'b1;
    cyc(Q);
    o_sda <= 1'b1;
    cyc(Q);
  endtask : stop

  // SDA moves in SCL low; optional 48 ns SCL spike
  task automatic wbit(input logic b, output logic r);
    cyc(40);
    o_sda <= b;
    cyc(60);
    o_scl <= spike;
    cyc(12);
    o_scl <= 1'b0;
    spike = 1'b0;
    cyc(Q - 112);
    o_scl <= 1'b1;
    cyc(Q);
    r = i_sda;
    o_scl <= 1'b0;
  endtask : wbit

  task automatic wbyte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      wbit(v[i], r);
    wbit(1'b1, r);
    ack = !r;
  endtask : wbyte

  // acknowledge continues a read, no acknowledge ends it
  task automatic rbyte(input logic mack, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--)
      wbit(1'b1, v[i]);
    wbit(!mack, r);
  endtask : rbyte
endmodule : eeprom_fe_master
`default_nettype wire

// *** eeprom_fe_monitor.sv ***
// Concurrent checks on the EEPROM front end's pins and core-side outputs.
// Assumes write protect is held steady across a write and its commit.
`timescale 1ns/100ps
`default_nettype none
module eeprom_fe_monitor
  import eeprom_fe_pkg::*;
#(
  parameter logic [TWR_W-1:0] WCYCLE_CYC = TWR_W'(TWR_CYC)  // Write cycle length
)(
  input wire logic              i_sys_clk,   // clock
  input wire logic              i_sys_rst,   // reset
  input wire logic              i_scl,       // SCL pin
  input wire logic              o_sda,       // SDA drive level
  input wire logic              o_sda_oe_n,  // low while pulling
  input wire logic              i_wp,        // write protect
  input wire logic [ADDR_W-1:0] o_mem_addr,  // pointer
  input wire mem_wr_s           o_mem_wr,    // page stream
  input wire logic              o_busy       // write cycle
);
  logic [7:0]       scl_low_reg, scl_low_next;
  logic [TWR_W-1:0] busy_len_reg, busy_len_next;

  // Pin-side low time saturates, only its lower bound is judged
  always_comb
  begin
    scl_low_next  = (i_scl || i_sys_rst) ? 8'h00 : scl_low_reg + {7'h00, scl_low_reg != 8'hFF};
    busy_len_next = (o_busy && !i_sys_rst) ? busy_len_reg + 1'b1 : '0;
  end
  always_ff @(posedge i_sys_clk)
  begin
    scl_low_reg  <= scl_low_next;
    busy_len_reg <= busy_len_next;
  end

  default clocking mon_cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_sys_rst);

  sequence held_low_s;
    !o_sda_oe_n [*8];
  endsequence

  drain_only_a:
    assert property (!o_sda_oe_n |-> o_sda == 1'b0)
    else $error("SDA drive level not low");
  move_late_a:
    assert property ($changed(o_sda_oe_n) |-> !i_scl && scl_low_reg >= HOLD_CYC + FILT_CYC)
    else $error("SDA drive changed too soon after SCL fall");
  ack_held_a:
    assert property ($rose(i_scl) && !o_sda_oe_n |-> held_low_s)
    else $error("SDA pull released during SCL high");
  reset_idle_a:
    assert property ($fell(i_sys_rst) |-> o_sda_oe_n && !o_busy && o_mem_addr == '0 && !o_mem_wr.valid)
    else $error("outputs not idle after reset");
  busy_silent_a:
    assert property (o_busy |-> o_sda_oe_n)
    else $error("SDA pulled during write cycle");
  protect_block_a:
    assert property (o_mem_wr.valid |-> !i_wp)
    else $error("memory write while protected");
  page_upper_a:
    assert property (o_mem_wr.valid |-> o_mem_wr.addr[10:4] == o_mem_addr[10:4])
    else $error("page write left its page");
  cycle_len_a:
    assert property ($fell(o_busy) |-> busy_len_reg >= WCYCLE_CYC && busy_len_reg <= WCYCLE_CYC + 24)
    else $error("write cycle length wrong");
endmodule : eeprom_fe_monitor

bind eeprom_two_wire_slave_front_end eeprom_fe_monitor #(.WCYCLE_CYC(WCYCLE_CYC)) u_mon
(
  .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_scl(i_scl), .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n),
  .i_wp(i_wp), .o_mem_addr(o_mem_addr), .o_mem_wr(o_mem_wr), .o_busy(o_busy)
);
`default_nettype wire

// *** eeprom_fe_pkg.sv ***
// Constants and carrier types for the two-wire EEPROM slave front end.
// Assumes a 250 MHz system clock and one front end per bus.
`default_nettype none
package eeprom_fe_pkg;
  localparam int unsigned CLK_NS       = 4;
  // Spike filter width and SDA hold after SCL fall, in ns
  localparam int unsigned FILT_NS      = 50;
  localparam int unsigned HOLD_NS      = 300;
  localparam int unsigned TWR_NS       = 10000000;
  localparam int unsigned FILT_CYC     = (FILT_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned HOLD_CYC     = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned TWR_CYC      = TWR_NS / CLK_NS;
  localparam int unsigned FILT_W       = 4;
  localparam int unsigned HOLD_W       = 7;
  localparam int unsigned TWR_W        = 22;

  localparam int unsigned ADDR_W       = 11;
  localparam int unsigned PAGE_BYTES   = 16;
  localparam int unsigned PAGE_W       = 4;
  // Control byte field positions
  localparam int unsigned CODE_MSB     = 7;
  localparam int unsigned CODE_LSB     = 4;
  localparam int unsigned BLK_MSB      = 3;
  localparam int unsigned BLK_LSB      = 1;
  localparam int unsigned RW_BIT       = 0;
  localparam logic [2:0]  LAST_BIT     = 3'h7;
  localparam logic [1:0]  BYTE_CTRL    = 2'h0;
  localparam logic [1:0]  BYTE_WADDR   = 2'h1;
  localparam logic [1:0]  BYTE_DATA    = 2'h2;

  typedef enum logic [4:0]
  {
    ST_IDLE = 5'h01,
    ST_RX   = 5'h02,
    ST_ACK  = 5'h04,
    ST_TX   = 5'h08,
    ST_MACK = 5'h10
  } link_state_e;

  typedef struct packed
  {
    logic              valid;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } mem_wr_s;

  typedef struct packed
  {
    logic              level;
    logic [FILT_W-1:0] cnt;
  } filt_s;
endpackage : eeprom_fe_pkg
`default_nettype wire

// *** eeprom_two_wire_slave_front_end.sv ***
// Two-wire slave front end of a serial EEPROM: filters the lines, finds START/STOP,
// shifts bytes, acknowledges, keeps a 16-byte page buffer and streams it to the core on STOP.
// Assumes a memory core that shows the byte at o_mem_addr on i_rd_data within a few cycles.
//
// Behaviour
// - Slave only; never drives SCL, never makes START or STOP.
// - SDA change while SCL high is taken as START or STOP.
// - Both lines high means the bus is idle.
// - SDA falling with SCL high is START; every command begins with one.
// - SDA rising with SCL high is STOP; every operation ends with one.
// - One SCL pulse per bit; SDA changes in SCL low, sampled in high.
// - Write keeps only the latest sixteen bytes, overwriting oldest first.
// - Every received addressed byte is acknowledged in a ninth clock.
// - No acknowledge at all while a programming cycle runs.
// - Acknowledge low is stable for the whole high phase of that clock.
// - On master no-acknowledge, release SDA so master can STOP.
// - First byte after START is control; top four bits are type code.
// - On type code match acknowledge, then read or write per direction bit.
// - Three block-select bits are the word address top three bits.
// - Direction bit one reads, zero writes.
// - When transmitting, change SDA at least 300 ns after SCL falls.
// - Glitches up to 50 ns on SDA and SCL are ignored.
// - STOP after write data starts the write cycle; busy until done.
// - Write data increments only the low four address bits.
// - Write-protect high blocks memory writes; reads still work.
`timescale 1ns/100ps
`default_nettype none
module eeprom_two_wire_slave_front_end
  import eeprom_fe_pkg::*;
#(
  parameter logic [3:0]       TYPE_CODE   = 4'h6,     // Arbitrary value
  parameter logic [TWR_W-1:0] WCYCLE_CYC  = TWR_W'(TWR_CYC)
)(
  input  wire logic              i_sys_clk,   // System clock
  input  wire logic              i_sys_rst,   // Synchronous reset
  input  wire logic              i_scl,       // Serial clock pin
  input  wire logic              i_sda,       // Serial data pin level
  output var  logic              o_sda,       // Serial data drive level
  output var  logic              o_sda_oe_n,  // Low while pulling SDA
  input  wire logic              i_wp,        // Write protect pin
  input  wire logic [7:0]        i_rd_data,   // Byte at o_mem_addr
  output var  logic [ADDR_W-1:0] o_mem_addr,  // Address pointer
  output var  mem_wr_s           o_mem_wr,    // Page write stream
  output var  logic              o_busy       // Write cycle running
);

  function automatic filt_s filt_step(input filt_s cur, input logic raw);
    filt_s nxt;
    nxt = cur;
    if (raw == cur.level)
      nxt.cnt = '0;
    else if (cur.cnt == FILT_W'(FILT_CYC))
    begin
      nxt.level = raw;
      nxt.cnt   = '0;
    end
    else
      nxt.cnt = cur.cnt + FILT_W'(1);
    return nxt;
  endfunction : filt_step

  // Input synchronisers and spike filters
  logic [1:0] scl_sync_reg, sda_sync_reg, wp_sync_reg;
  filt_s      scl_f_reg, scl_f_next, sda_f_reg, sda_f_next;
  logic       scl_d_reg, sda_d_reg;

  always_comb
  begin
    scl_f_next = filt_step(scl_f_reg, scl_sync_reg[1]);
    sda_f_next = filt_step(sda_f_reg, sda_sync_reg[1]);
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      wp_sync_reg  <= 2'h0;
      scl_f_reg    <= '{level: 1'b1, cnt: '0};
      sda_f_reg    <= '{level: 1'b1, cnt: '0};
      scl_d_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
    end
    else
    begin
      scl_sync_reg <= {scl_sync_reg[0], i_scl};
      sda_sync_reg <= {sda_sync_reg[0], i_sda};
      wp_sync_reg  <= {wp_sync_reg[0], i_wp};
      scl_f_reg    <= scl_f_next;
      sda_f_reg    <= sda_f_next;
      scl_d_reg    <= scl_f_reg.level;
      sda_d_reg    <= sda_f_reg.level;
    end
  end

  logic scl_rise, scl_fall, start_cond, stop_cond;
  assign scl_rise   = scl_f_reg.level & ~scl_d_reg;
  assign scl_fall   = ~scl_f_reg.level & scl_d_reg;
  assign start_cond = scl_f_reg.level & scl_d_reg & sda_d_reg & ~sda_f_reg.level;
  assign stop_cond  = scl_f_reg.level & scl_d_reg & ~sda_d_reg & sda_f_reg.level;

  // Protocol state
  link_state_e             state_reg, state_next;
  logic [2:0]              bit_reg, bit_next;
  logic [7:0]              shift_reg, shift_next;
  logic                    done_reg, done_next;
  logic [1:0]              byte_reg, byte_next;
  logic                    rw_reg, rw_next;
  logic [ADDR_W-1:0]       ptr_reg, ptr_next;
  logic                    want_reg, want_next;
  logic [HOLD_W-1:0]       hold_reg, hold_next;
  logic                    oe_n_reg, oe_n_next;
  logic [PAGE_BYTES-1:0]   mask_reg, mask_next;
  logic                    flush_reg, flush_next;
  logic [PAGE_W-1:0]       fidx_reg, fidx_next;
  logic [TWR_W-1:0]        wcyc_reg, wcyc_next;
  mem_wr_s                 wr_reg, wr_next;
  logic                    busy;
  logic                    buf_we;
  logic [7:0]              page_buf [PAGE_BYTES];

  assign busy = flush_reg | (wcyc_reg != '0);

  always_comb
  begin
    state_next = state_reg;
    bit_next   = bit_reg;
    shift_next = shift_reg;
    done_next  = done_reg;
    byte_next  = byte_reg;
    rw_next    = rw_reg;
    ptr_next   = ptr_reg;
    want_next  = want_reg;
    hold_next  = hold_reg;
    oe_n_next  = oe_n_reg;
    mask_next  = mask_reg;
    flush_next = flush_reg;
    fidx_next  = fidx_reg;
    wcyc_next  = wcyc_reg;
    wr_next    = '0;
    buf_we     = 1'b0;

    if (hold_reg != '0)
    begin
      hold_next = hold_reg - HOLD_W'(1);
      if (hold_reg == HOLD_W'(1))
        oe_n_next = ~want_reg;
    end

    if (flush_reg)
    begin
      wr_next.valid = mask_reg[fidx_reg];
      wr_next.addr  = {ptr_reg[ADDR_W-1:PAGE_W], fidx_reg};
      wr_next.data  = page_buf[fidx_reg];
      fidx_next     = fidx_reg + PAGE_W'(1);
      if (fidx_reg == PAGE_W'(PAGE_BYTES - 1))
      begin
        flush_next = 1'b0;
        mask_next  = '0;
        wcyc_next  = WCYCLE_CYC;
      end
    end
    else if (wcyc_reg != '0)
      wcyc_next = wcyc_reg - TWR_W'(1);

    if (start_cond)
    begin
      state_next = ST_RX;
      bit_next   = '0;
      done_next  = 1'b0;
      byte_next  = BYTE_CTRL;
      oe_n_next  = 1'b1;
      hold_next  = '0;
      if (!flush_reg)
        mask_next = '0;
    end
    else if (stop_cond)
    begin
      state_next = ST_IDLE;
      oe_n_next  = 1'b1;
      hold_next  = '0;
      if (!busy && !rw_reg && byte_reg == BYTE_DATA && mask_reg != '0 && !wp_sync_reg[1])
      begin
        flush_next = 1'b1;
        fidx_next  = '0;
      end
      else if (!flush_reg)
        mask_next = '0;
    end
    else
    begin
      unique case (state_reg)
        ST_IDLE:
        begin
        end
        ST_RX:
        begin
          if (scl_rise)
          begin
            shift_next = {shift_reg[6:0], sda_f_reg.level};
            bit_next   = bit_reg + 3'h1;
            done_next  = (bit_reg == LAST_BIT);
          end
          else if (scl_fall && done_reg)
          begin
            done_next = 1'b0;
            hold_next = HOLD_W'(HOLD_CYC);
            want_next = 1'b1;
            state_next = ST_ACK;
            unique case (byte_reg)
              BYTE_CTRL:
              begin
                if (shift_reg[CODE_MSB:CODE_LSB] != TYPE_CODE || busy)
                begin
                  state_next = ST_IDLE;
                  want_next  = 1'b0;
                end
                else
                begin
                  ptr_next[ADDR_W-1:ADDR_W-3] = shift_reg[BLK_MSB:BLK_LSB];
                  rw_next   = shift_reg[RW_BIT];
                  byte_next = BYTE_WADDR;
                end
              end
              BYTE_WADDR:
              begin
                ptr_next[7:0] = shift_reg;
                byte_next     = BYTE_DATA;
              end
              default:
              begin
                buf_we                   = 1'b1;
                mask_next[ptr_reg[PAGE_W-1:0]] = 1'b1;
                ptr_next[PAGE_W-1:0]     = ptr_reg[PAGE_W-1:0] + PAGE_W'(1);
              end
            endcase
          end
        end
        ST_ACK:
        begin
          // ack held through SCL high, ninth clock
          if (scl_fall)
          begin
            hold_next = HOLD_W'(HOLD_CYC);
            bit_next  = '0;
            if (rw_reg)
            begin
              state_next = ST_TX;
              shift_next = i_rd_data;
              want_next  = ~i_rd_data[7];
            end
            else
            begin
              state_next = ST_RX;
              want_next  = 1'b0;
            end
          end
        end
        ST_TX:
        begin
          if (scl_fall)
          begin
            hold_next = HOLD_W'(HOLD_CYC);
            if (bit_reg == LAST_BIT)
            begin
              state_next = ST_MACK;
              want_next  = 1'b0;
              bit_next   = '0;
            end
            else
            begin
              bit_next   = bit_reg + 3'h1;
              shift_next = {shift_reg[6:0], 1'b0};
              want_next  = ~shift_reg[6];
            end
          end
        end
        ST_MACK:
        begin
          if (scl_rise)
          begin
            ptr_next  = ptr_reg + ADDR_W'(1);
            done_next = ~sda_f_reg.level;
            if (sda_f_reg.level)
              state_next = ST_IDLE;
          end
          else if (scl_fall && done_reg)
          begin
            done_next  = 1'b0;
            state_next = ST_TX;
            hold_next  = HOLD_W'(HOLD_CYC);
            shift_next = i_rd_data;
            want_next  = ~i_rd_data[7];
          end
        end
        default:
          state_next = ST_IDLE;
      endcase
    end
  end

  // Page buffer written in place by pointer, so a wrap overwrites the oldest byte
  always_ff @(posedge i_sys_clk)
  begin
    if (buf_we)
      page_buf[ptr_reg[PAGE_W-1:0]] <= shift_reg;
  end

  // reset to idle with SDA released
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      state_reg <= ST_IDLE;
      bit_reg   <= '0;
      shift_reg <= '0;
      done_reg  <= 1'b0;
      byte_reg  <= BYTE_CTRL;
      rw_reg    <= 1'b0;
      ptr_reg   <= '0;
      want_reg  <= 1'b0;
      hold_reg  <= '0;
      oe_n_reg  <= 1'b1;
      mask_reg  <= '0;
      flush_reg <= 1'b0;
      fidx_reg  <= '0;
      wcyc_reg  <= '0;
      wr_reg    <= '0;
    end
    else
    begin
      state_reg <= state_next;
      bit_reg   <= bit_next;
      shift_reg <= shift_next;
      done_reg  <= done_next;
      byte_reg  <= byte_next;
      rw_reg    <= rw_next;
      ptr_reg   <= ptr_next;
      want_reg  <= want_next;
      hold_reg  <= hold_next;
      oe_n_reg  <= oe_n_next;
      mask_reg  <= mask_next;
      flush_reg <= flush_next;
      fidx_reg  <= fidx_next;
      wcyc_reg  <= wcyc_next;
      wr_reg    <= wr_next;
    end
  end

  // Busy output lags one cycle; the control-byte check uses the live term
  logic busy_reg;
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
      busy_reg <= 1'b0;
    else
      busy_reg <= busy;
  end

  assign o_sda      = 1'b0;
  assign o_sda_oe_n = oe_n_reg;
  assign o_mem_addr = ptr_reg;
  assign o_mem_wr   = wr_reg;
  assign o_busy     = busy_reg;

endmodule : eeprom_two_wire_slave_front_end
`default_nettype wire

// *** eeprom_two_wire_slave_front_end_tb_top.sv ***
// Self-checking bench for the EEPROM two-wire slave front end.
// Assumes package, front end, master model and monitor compiled first.
`timescale 1ns/100ps
`default_nettype none
module eeprom_two_wire_slave_front_end_tb_top;
  import eeprom_fe_pkg::*;
  localparam logic [3:0] CODE = 4'h6;  // Arbitrary type code
  localparam int         WCYC = 5000;  // Shortened write cycle
  logic              sys_clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic              wp = 1'b0;
  logic              m_scl, m_sda, sda_oe_n, sda_lvl, busy, ack;
  logic [7:0]        rd_data = 8'h00;
  logic [7:0]        d;
  logic [7:0]        page [16];
  logic [6:0]        page_hi;
  logic [ADDR_W-1:0] mem_addr;
  mem_wr_s           mem_wr;
  int                num_errors = 0;
  int                cmp_count = 0;
  int                wr_cnt = 0;
  wire logic         bus_sda;

  // single device on a pulled-up line
  assign bus_sda = m_sda & (sda_oe_n | sda_lvl);
  always #2 sys_clk = ~sys_clk;

  eeprom_two_wire_slave_front_end #(.TYPE_CODE(CODE), .WCYCLE_CYC(TWR_W'(WCYC))) uut
  (
    .i_sys_clk(sys_clk), .i_sys_rst(sys_rst), .i_scl(m_scl), .i_sda(bus_sda), .o_sda(sda_lvl),
    .o_sda_oe_n(sda_oe_n), .i_wp(wp), .i_rd_data(rd_data), .o_mem_addr(mem_addr), .o_mem_wr(mem_wr),
    .o_busy(busy)
  );
  eeprom_fe_master m (.i_sys_clk(sys_clk), .i_sda(bus_sda), .o_scl(m_scl), .o_sda(m_sda));

  function automatic logic [7:0] mem_byte(input logic [10:0] a);
    return a[7:0] ^ {a[10:8], 5'h00};
  endfunction : mem_byte
  function automatic logic [7:0] ctl(input logic [2:0] blk, input logic rw);
    return {CODE, blk, rw};
  endfunction : ctl

  // Core stand-in and page capture
  always @(posedge sys_clk)
  begin
    rd_data <= mem_byte(mem_addr);
    if (mem_wr.valid === 1'b1)
    begin
      page[mem_wr.addr[3:0]] <= mem_wr.data;
      page_hi                <= mem_wr.addr[10:4];
      wr_cnt                 <= wr_cnt + 1;
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  task automatic send(input logic [7:0] v, input logic exp);
    m.wbyte(v, ack);
    chk(16'(ack), 16'(exp));
  endtask : send

  task automatic wait_idle();
    for (int n = 0; n < 2 * WCYC && busy !== 1'b0; n++)
      @(posedge sys_clk);
    if (busy !== 1'b0)
    begin
      chk(16'(busy), 16'h0);
      report_and_stop();
    end
  endtask : wait_idle

  task automatic t_reset();
    chk(16'(sda_oe_n), 16'h1);
    chk(16'(mem_addr), 16'h0);
    chk(16'(busy), 16'h0);
  endtask : t_reset

  task automatic t_bad_code();
    m.start();
    send({CODE ^ 4'h2, 4'h0}, 1'b0);
    m.stop();
  endtask : t_bad_code

  // Seventeen bytes from 3E: the last one lands on slot E again
  task automatic t_page_write();
    wr_cnt <= 0;
    m.start();
    send(ctl(3'h5, 1'b0), 1'b1);
    send(8'h3E, 1'b1);
    for (int k = 0; k < 17; k++)
      send(8'(8'h40 + k), 1'b1);
    m.stop();
    m.start();
    send(ctl(3'h5, 1'b0), 1'b0);
    m.stop();
    wait_idle();
    m.start();
    send(ctl(3'h5, 1'b0), 1'b1);
    m.stop();
    chk(16'(wr_cnt), 16'h10);
    chk(16'(page_hi), 16'h53);
    for (int s = 0; s < 16; s++)
      chk(16'(page[s]), 16'((s == 14) ? 8'h50 : 8'(8'h40 + ((s + 2) & 15))));
  endtask : t_page_write

  task automatic t_read();
    m.start();
    send(ctl(3'h2, 1'b0), 1'b1);
    m.spike = 1'b1;
    send(8'h20, 1'b1);
    m.start();
    send(ctl(3'h2, 1'b1), 1'b1);
    m.rbyte(1'b1, d);
    chk(16'(d), 16'(mem_byte(11'h220)));
    m.rbyte(1'b0, d);
    chk(16'(d), 16'(mem_byte(11'h221)));
    m.cyc(120);
    chk(16'(sda_oe_n), 16'h1);
    m.stop();
  endtask : t_read

  task automatic t_protect();
    wp <= 1'b1;
    wr_cnt <= 0;
    m.start();
    send(ctl(3'h1, 1'b0), 1'b1);
    send(8'h05, 1'b1);
    send(8'hAA, 1'b1);
    m.stop();
    m.cyc(40);
    chk(16'(wr_cnt), 16'h0);
    // Reads still work while protected; pointer sits one past the blocked byte
    m.start();
    send(ctl(3'h1, 1'b1), 1'b1);
    m.rbyte(1'b0, d);
    chk(16'(d), 16'(mem_byte(11'h106)));
    m.stop();
    wp <= 1'b0;
  endtask : t_protect

  initial
  begin
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    m.cyc(8);
    t_reset();
    t_bad_code();
    t_page_write();
    t_read();
    t_protect();
    report_and_stop();
  end
endmodule : eeprom_two_wire_slave_front_end_tb_top
`default_nettype wire
